//--- design/cac_top.sv
// Chip address configuration register behind the serial bus pins
`timescale 1ns/10ps
`include "cac_regs.svh"
// How it works
// - 8-bit register: hi b3, lo b2, lock b0
// - Only the auxiliary type code selects it
// - Address top bits 110 route to register
// - Remaining address bits are ignored
// - Random read and page write framing
// - Bits b3 b2 form chip enable address
// - Active bits reload at power-up, after write
// - Lock one makes register read-only
// - Lock set means bits change again only at reset, to preset
// - More than one data byte aborts write
// - Inhibit or lock: data not acknowledged
// - Bits b7..b4 and b1 read zero
// - Standard part ships all zero
// - One write updates address and lock together
// - Preset variant ships address set, locked
// - Inhibit input high blocks every write

module cac_top #(
  parameter logic [3:0]  TYPE_CODE    = 4'h5, // Arbitrary value
  parameter logic [7:0]  PRESET_CFG   = `CAC_RESET_VAL,
  parameter int unsigned WRITE_CYCLES = `CAC_T_WRITE_NS / `CAC_CLK_NS
) (
  input  wire logic i_clk,
  input  wire logic i_reset_n,
  input  wire logic i_scl,
  input  wire logic i_sda,
  output logic      o_sda_o,
  output logic      o_sda_oe,
  input  wire logic i_write_inhibit_in,
  output logic      o_chip_enable_addr_hi,
  output logic      o_chip_enable_addr_lo,
  output logic      o_address_lock,
  output logic      o_write_busy
);

  logic [1:0]             rst_sync_ff;
  logic                   rst_n;
  logic [2:0]             pin_raw;
  logic [2:0]             pin_f;
  logic [2:0]             pin_p;
  logic                   scl_rise;
  logic                   scl_fall;
  logic                   start_det;
  logic                   stop_det;
  logic                   wc;
  cac_pkg::cac_state_type state_ff;
  cac_pkg::cac_state_type nxt_state;
  logic [3:0]             bit_cnt_ff;
  logic                   ack_ph_ff;
  logic [7:0]             shift_ff;
  logic                   sda_oe_ff;
  logic                   byte_end;
  logic                   ack_ok;
  logic                   reg_sel_ff;
  logic [1:0]             data_cnt_ff;
  logic [7:0]             wr_byte_ff;
  logic                   wr_start;
  logic [2:0]             wr_data;
  logic [2:0]             act;
  logic                   busy;
  logic [7:0]             rd_byte;

  // Reset release through two flops
  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_sync_ff <= 2'h0;
    end else begin
      rst_sync_ff <= {rst_sync_ff[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_ff[1];

  // Pin synchronisers, a change counts when stages two and three agree
  assign pin_raw = {i_write_inhibit_in, i_sda, i_scl};
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      logic [2:0] sync_ff;
      logic       filt_ff;
      logic       prev_ff;
      always_ff @(posedge i_clk or negedge rst_n) begin
        if (!rst_n) begin
          sync_ff <= 3'h7;
          filt_ff <= 1'b1;
          prev_ff <= 1'b1;
        end else begin
          sync_ff <= {sync_ff[1:0], pin_raw[g]};
          if (sync_ff[1] == sync_ff[2]) begin
            filt_ff <= sync_ff[2];
          end
          prev_ff <= filt_ff;
        end
      end
      assign pin_f[g] = filt_ff;
      assign pin_p[g] = prev_ff;
    end
  endgenerate

  // Bus events
  assign wc        = pin_f[2];
  assign scl_rise  = pin_f[0] && !pin_p[0];
  assign scl_fall  = !pin_f[0] && pin_p[0];
  assign start_det = pin_f[0] && pin_p[0] && pin_p[1] && !pin_f[1];
  assign stop_det  = pin_f[0] && pin_p[0] && !pin_p[1] && pin_f[1];
  assign byte_end  = scl_fall && !ack_ph_ff && (bit_cnt_ff == 4'h8);

  // Read image, unused bits forced low
  assign rd_byte = {4'h0, act[2], act[1], 1'b0, act[0]};

  // Acknowledge decision at the end of each received byte
  always_comb begin
    ack_ok    = 1'b0;
    nxt_state = cac_pkg::ST_IGNORE;
    case (state_ff)
      cac_pkg::ST_DEVSEL: begin
        if (shift_ff[7:4] == TYPE_CODE && shift_ff[3:2] == act[2:1] && !busy) begin
          ack_ok    = 1'b1;
          nxt_state = shift_ff[0] ? cac_pkg::ST_RDATA : cac_pkg::ST_ADDR_HI;
        end
      end
      cac_pkg::ST_ADDR_HI: begin
        ack_ok    = 1'b1;
        nxt_state = cac_pkg::ST_ADDR_LO;
      end
      cac_pkg::ST_ADDR_LO: begin
        ack_ok    = 1'b1;
        nxt_state = cac_pkg::ST_WDATA;
      end
      cac_pkg::ST_WDATA: begin
        if (reg_sel_ff && !wc && !act[0]) begin
          ack_ok    = 1'b1;
          nxt_state = cac_pkg::ST_WDATA;
        end
      end
      default: begin
        ack_ok    = 1'b0;
      end
    endcase
  end

  // Bit engine and byte sequencer
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff   <= cac_pkg::ST_IDLE;
      bit_cnt_ff <= 4'h0;
      ack_ph_ff  <= 1'b0;
      shift_ff   <= 8'h00;
      sda_oe_ff  <= 1'b0;
    end else if (start_det) begin
      state_ff   <= cac_pkg::ST_DEVSEL;
      bit_cnt_ff <= 4'h0;
      ack_ph_ff  <= 1'b0;
      sda_oe_ff  <= 1'b0;
    end else if (stop_det) begin
      state_ff   <= cac_pkg::ST_IDLE;
      ack_ph_ff  <= 1'b0;
      sda_oe_ff  <= 1'b0;
    end else if (scl_rise) begin
      if (!ack_ph_ff && bit_cnt_ff != 4'h8) begin
        shift_ff   <= {shift_ff[6:0], pin_f[1]};
        bit_cnt_ff <= bit_cnt_ff + 4'h1;
      end else if (ack_ph_ff && state_ff == cac_pkg::ST_RDATA && pin_f[1]) begin
        state_ff <= cac_pkg::ST_IGNORE; // Master ended the read
      end
    end else if (scl_fall) begin
      if (byte_end) begin
        ack_ph_ff <= 1'b1;
        if (state_ff == cac_pkg::ST_RDATA) begin
          sda_oe_ff <= 1'b0;
        end else begin
          sda_oe_ff <= ack_ok;
          state_ff  <= nxt_state;
        end
      end else if (ack_ph_ff) begin
        ack_ph_ff  <= 1'b0;
        bit_cnt_ff <= 4'h0;
        sda_oe_ff  <= state_ff == cac_pkg::ST_RDATA && reg_sel_ff && !rd_byte[7];
      end else begin
        sda_oe_ff  <= state_ff == cac_pkg::ST_RDATA && reg_sel_ff
                      && !rd_byte[~bit_cnt_ff[2:0]];
      end
    end
  end

  // Register selection and data byte capture
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_sel_ff  <= 1'b0;
      data_cnt_ff <= 2'h0;
      wr_byte_ff  <= 8'h00;
    end else if (byte_end) begin
      case (state_ff)
        cac_pkg::ST_ADDR_HI: begin
          reg_sel_ff <= shift_ff[7:5] == `CAC_SEL_PATTERN;
        end
        cac_pkg::ST_ADDR_LO: begin
          data_cnt_ff <= 2'h0;
        end
        cac_pkg::ST_WDATA: begin
          if (ack_ok && data_cnt_ff == 2'h0) begin
            wr_byte_ff <= shift_ff;
          end
          if (ack_ok && data_cnt_ff != 2'h2) begin
            data_cnt_ff <= data_cnt_ff + 2'h1;
          end
        end
        default: begin
          data_cnt_ff <= data_cnt_ff;
        end
      endcase
    end
  end

  // Commit only a single-byte write at stop
  assign wr_start = stop_det && state_ff == cac_pkg::ST_WDATA
                    && data_cnt_ff == `CAC_CNT_BYTES;
  assign wr_data  = {wr_byte_ff[`CAC_BIT_CE_HI], wr_byte_ff[`CAC_BIT_CE_LO],
                     wr_byte_ff[`CAC_BIT_LOCK]};

  cac_nvcell #(
    .PRESET       ({PRESET_CFG[`CAC_BIT_CE_HI], PRESET_CFG[`CAC_BIT_CE_LO],
                    PRESET_CFG[`CAC_BIT_LOCK]}),
    .WRITE_CYCLES (WRITE_CYCLES)
  ) u_cell (
    .i_clk      (i_clk),
    .i_rst_n    (rst_n),
    .i_wr_start (wr_start),
    .i_wr_data  (wr_data),
    .o_active   (act),
    .o_busy     (busy)
  );

  // Outputs
  assign o_sda_o               = 1'b0;
  assign o_sda_oe              = sda_oe_ff;
  assign o_chip_enable_addr_hi = act[2];
  assign o_chip_enable_addr_lo = act[1];
  assign o_address_lock        = act[0];
  assign o_write_busy          = busy;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  sequence s_end_of(cac_pkg::cac_state_type st);
    byte_end && state_ff == st;
  endsequence

  type_nack_a : assert property (
    s_end_of(cac_pkg::ST_DEVSEL) ##0 (shift_ff[7:4] != TYPE_CODE) |=> !sda_oe_ff)
    else $error("foreign type code acknowledged");
  ce_nack_a : assert property (
    s_end_of(cac_pkg::ST_DEVSEL) ##0 (shift_ff[3:2] != act[2:1]) |=> !sda_oe_ff)
    else $error("wrong chip enable address acknowledged");
  sel_route_a : assert property (
    s_end_of(cac_pkg::ST_ADDR_HI) |=> reg_sel_ff == ($past(shift_ff[7:5]) == 3'h6))
    else $error("register selection wrong");
  low_ignore_a : assert property (
    s_end_of(cac_pkg::ST_ADDR_LO) |=> $stable(reg_sel_ff) && sda_oe_ff)
    else $error("low address byte affected selection");
  lock_nack_a : assert property (
    s_end_of(cac_pkg::ST_WDATA) ##0 act[0]
    |=> !sda_oe_ff ##1 (state_ff == cac_pkg::ST_IGNORE || start_det || stop_det))
    else $error("data acknowledged while locked");
  inhibit_nack_a : assert property (
    s_end_of(cac_pkg::ST_WDATA) ##0 wc |=> !sda_oe_ff)
    else $error("data acknowledged while write inhibited");
  multi_abort_a : assert property (
    stop_det && state_ff == cac_pkg::ST_WDATA && data_cnt_ff != 2'h1
    |-> !wr_start ##1 !busy)
    else $error("multi-byte write not aborted");
  read_zero_a : assert property (
    scl_fall && state_ff == cac_pkg::ST_RDATA && !ack_ph_ff && reg_sel_ff
    && bit_cnt_ff inside {[4'h1:4'h3]} && !start_det && !stop_det |=> sda_oe_ff)
    else $error("unused read bit not zero");

endmodule

//--- design/cac_regs.svh
// Constants of the chip address configuration register
`ifndef CAC_REGS_SVH
`define CAC_REGS_SVH

`define CAC_RESET_VAL   8'h00
`define CAC_BIT_CE_HI   3
`define CAC_BIT_CE_LO   2
`define CAC_BIT_LOCK    0
`define CAC_SEL_PATTERN 3'h6
`define CAC_CNT_BYTES   2'h1
`define CAC_CLK_NS      5
`define CAC_T_WRITE_NS  4000000

`endif

//--- design/cac_pkg.sv
// Types of the chip address configuration register
package cac_pkg;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h0,
    ST_DEVSEL  = 3'h1,
    ST_ADDR_HI = 3'h2,
    ST_ADDR_LO = 3'h3,
    ST_WDATA   = 3'h4,
    ST_RDATA   = 3'h5,
    ST_IGNORE  = 3'h6
  } cac_state_type;

endpackage

//--- design/cac_nvcell.sv
// Non-volatile cell and active copy of the configuration bits
`timescale 1ns/10ps
`include "cac_regs.svh"

module cac_nvcell #(
  parameter logic [2:0]  PRESET       = 3'h0,
  parameter int unsigned WRITE_CYCLES = `CAC_T_WRITE_NS / `CAC_CLK_NS
) (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_wr_start,
  input  wire logic [2:0] i_wr_data,
  output logic      [2:0] o_active,
  output logic            o_busy
);

  logic [2:0]  stored_ff;
  logic [2:0]  pend_ff;
  logic [2:0]  act_ff;
  logic [19:0] cnt_ff;
  logic        busy_ff;
  logic        load_ff;
  logic        done;

  assign done     = busy_ff && (cnt_ff == 20'h00001);
  assign o_active = act_ff;
  assign o_busy   = busy_ff;

  // Write cycle timer, refused while locked
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_ff <= 1'b0;
      cnt_ff  <= 20'h00000;
      pend_ff <= 3'h0;
    end else if (!busy_ff && i_wr_start && !act_ff[0]) begin
      busy_ff <= 1'b1;
      cnt_ff  <= 20'(WRITE_CYCLES);
      pend_ff <= i_wr_data;
    end else if (busy_ff) begin
      busy_ff <= !done;
      cnt_ff  <= cnt_ff - 20'h00001;
    end
  end

  // Stored bits, preset value at power-on
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      stored_ff <= PRESET;
    end else if (done) begin
      stored_ff <= pend_ff;
    end
  end

  // Active copy reloads after power-up and each write
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      act_ff  <= PRESET;
      load_ff <= 1'b1;
    end else if (load_ff) begin
      act_ff  <= stored_ff;
      load_ff <= 1'b0;
    end else begin
      load_ff <= done;
    end
  end

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  sequence s_write_done;
    done ##1 load_ff;
  endsequence

  reload_after_write_a : assert property (s_write_done |=> act_ff == stored_ff)
    else $error("active bits not reloaded after write");
  lock_freeze_a : assert property (act_ff[0] && !busy_ff |=> $stable(stored_ff))
    else $error("locked cell changed");
  locked_refuse_a : assert property (act_ff[0] && !busy_ff |=> !busy_ff)
    else $error("write cycle started while locked");

endmodule

//--- verification/cac_bus_master.sv
// Serial bus master model for the configuration register
`timescale 1ns/10ps

module cac_bus_master (
  input  wire logic i_clk,
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_low
);
  // Idle bus: clock stands high, data released
  initial begin
    o_scl     = 1'b1;
    o_sda_low = 1'b0;
  end

  // Wait a number of system clocks
  task automatic q(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  // One bit of 32 clocks: data set mid-low, sampled mid-high
  task automatic bx(input logic b, output logic r);
    o_sda_low <= ~b;
    q(8);
    o_scl <= 1'b1;
    q(8);
    r = i_sda;
    q(8);
    o_scl <= 1'b0;
    q(8);
  endtask

  // Start or repeated start
  task automatic start();
    o_sda_low <= 1'b0;
    q(8);
    o_scl <= 1'b1;
    q(16);
    o_sda_low <= 1'b1;
    q(16);
    o_scl <= 1'b0;
    q(8);
  endtask

  // Stop, leaving the clock high
  task automatic stop();
    o_sda_low <= 1'b1;
    q(8);
    o_scl <= 1'b1;
    q(16);
    o_sda_low <= 1'b0;
    q(16);
  endtask

  // Byte out, most significant bit first, then ack slot
  task automatic wb(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bx(d[i], r);
    bx(1'b1, r);
    ack = ~r;
  endtask

  // Byte in, ended by a master no-ack
  task automatic rb(output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--) bx(1'b1, d[i]);
    bx(1'b1, r);
  endtask

  // Page-write framing with junk in the unused address bits
  task automatic wr(input logic [3:0] t, input logic [1:0] ce, input logic [2:0] top,
                    input int n, input logic [7:0] v, output logic [3:0] ak);
    start();
    wb({t, ce, 2'b00}, ak[0]);
    wb({top, 5'($urandom)}, ak[1]);
    wb(8'($urandom), ak[2]);
    repeat (n) wb(v, ak[3]);
    stop();
  endtask

  // Random-address read framing
  task automatic rd(input logic [3:0] t, input logic [1:0] ce, output logic ok,
                    output logic [7:0] d);
    start();
    wb({t, ce, 2'b00}, ok);
    wb({3'h6, 5'($urandom)}, ok);
    wb(8'($urandom), ok);
    start();
    wb({t, ce, 2'b01}, ok);
    rb(d);
    stop();
  endtask
endmodule

//--- verification/chip_address_config_register_tb_top.sv
// Self-checking bench of the chip address configuration register
`timescale 1ns/10ps

module chip_address_config_register_tb_top;
  localparam logic [3:0] TC = 4'h5; // Arbitrary type code
  logic       i_clk, i_reset_n, scl, sda_low, sda, sda_oe, inh, hi, lo, lock, busy, ok;
  logic [3:0] ak;
  logic [7:0] d;
  logic       sda_o;
  int         m, n_fail, compares, cyc;

  // Pull-up on the shared data wire, device pulls only when enabled
  assign sda = ~(sda_low | (sda_oe & ~sda_o));

  cac_top #(.TYPE_CODE(TC), .WRITE_CYCLES(20)) u_cac_top (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_scl(scl), .i_sda(sda), .o_sda_o(sda_o),
    .o_sda_oe(sda_oe), .i_write_inhibit_in(inh), .o_chip_enable_addr_hi(hi),
    .o_chip_enable_addr_lo(lo), .o_address_lock(lock), .o_write_busy(busy));

  cac_bus_master u_cac_bus_master (
    .i_clk(i_clk), .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));

  // 200 MHz clock
  initial begin
    i_clk = 1'b0;
    forever #2.5 i_clk = ~i_clk;
  end

  // Compare and count
  task automatic chk(input string s, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", s, e, g);
    end
  endtask

  // Verdict and end of run
  task automatic report_and_stop();
    $display("fails %0d compares %0d", n_fail, compares);
    if (n_fail == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Read back and pin outputs against the model
  task automatic expect_state();
    u_cac_bus_master.rd(TC, 2'(m >> 2), ok, d);
    chk("select", 8'h1, 8'(ok));
    chk("readback", 8'(m), d);
    chk("pins", 8'(m), {4'h0, hi, lo, 1'b0, lock});
  endtask

  // Busy after stop as expected, then wait for idle
  task automatic fin(input logic w);
    chk("busy", 8'(w), 8'(busy));
    for (int i = 0; i < 200 && busy !== 1'b0; i++) @(posedge i_clk);
    repeat (4) @(posedge i_clk);
  endtask

  // Hang guard
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      n_fail++;
      report_and_stop();
    end
  end

  // Main sequence
  initial begin
    void'($urandom(32'hC25E));
    i_reset_n = 1'b0;
    inh       = 1'b0;
    m         = 0;
    n_fail    = 0;
    compares  = 0;
    cyc       = 0;
    repeat (3) @(posedge i_clk);
    i_reset_n <= 1'b1;
    repeat (12) @(posedge i_clk);
    expect_state();
    // Every chip enable address, junk in the unused bits
    for (int k = 0; k < 4; k++) begin
      d = {4'($urandom), 2'(k), 1'($urandom), 1'b0};
      u_cac_bus_master.wr(TC, 2'(m >> 2), 3'h6, 1, d, ak);
      chk("acks", 8'hF, 8'(ak));
      fin(1'b1);
      m = k << 2;
      expect_state();
      // The chip enable address with bit 0 flipped is ignored
      u_cac_bus_master.rd(TC, 2'(m >> 2) ^ 2'h1, ok, d);
      chk("foreign ce", 8'h0, 8'(ok));
      chk("foreign data", 8'hFF, d);
    end
    // Refused writes: inhibit, foreign type, other register, two bytes
    for (int c = 0; c < 4; c++) begin
      inh <= (c == 0);
      u_cac_bus_master.wr(c == 1 ? TC ^ 4'h3 : TC, 2'(m >> 2), c == 2 ? 3'h5 : 3'h6,
                          c == 3 ? 2 : 1, 8'h00, ak);
      chk("acks", c == 1 ? 8'h0 : (c == 3 ? 8'hF : 8'h7), 8'(ak));
      fin(1'b0);
      expect_state();
    end
    inh <= 1'b0;
    // Address and lock together in one write
    u_cac_bus_master.wr(TC, 2'(m >> 2), 3'h6, 1, 8'h05, ak);
    chk("acks", 8'hF, 8'(ak));
    fin(1'b1);
    m = 5;
    expect_state();
    // Locked register refuses further writes
    u_cac_bus_master.wr(TC, 2'(m >> 2), 3'h6, 1, 8'h08, ak);
    chk("acks", 8'h7, 8'(ak));
    fin(1'b0);
    expect_state();
    report_and_stop();
  end
endmodule
